// File: lmp_lamp54.sv
// Lamp 4 and lamp 5 function select and pin polarity, AHB-Lite slave.
// Assumes indications synchronous to mclk and a strap stable at reset.
`timescale 1ns/1ps
`default_nettype none
`include "lmp_regs.svh"

module lmp_lamp54 #(
  parameter int BLINK_CYC = `LMP_BLINK_NS / `LMP_CLK_NS
) (
  input  wire  logic             mclk,
  input  wire  logic             sys_rst,
  input  wire  logic             hsel,
  input  wire  logic [31:0]      haddr,
  input  wire  logic [1:0]       htrans,
  input  wire  logic             hwrite,
  input  wire  logic [2:0]       hsize,
  input  wire  logic [31:0]      hwdata,
  input  wire  logic             hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire  logic [1:0]       lamp_config_strap,
  input  wire  lmp_pkg::lmp_ind_t ind,
  output lmp_pkg::lmp_pin_t      lamp4_pin,
  output lmp_pkg::lmp_pin_t      lamp5_pin
);
  import lmp_pkg::*;

  // ****************************************************************
  // Lamp function decode
  // ****************************************************************
  // Shared by both lamps; codes 1010 and 1011 differ between them.
  function automatic lmp_lamp_t lamp_eval(
    input logic [3:0] code,
    input logic       is5,
    input lmp_ind_t   s,
    input logic       bl
  );
    lmp_lamp_t r;
    logic      act;
    r   = '0;
    act = s.rx | s.tx;
    case (code)
      `LMP_F_RX:      r.on = s.rx;
      `LMP_F_LNK_ACT: r.on = s.link & ~(act & bl);
      `LMP_F_LNK_RX:  r.on = s.link & ~(s.rx & bl);
      `LMP_F_ACT:     r.on = act;
      `LMP_F_BLK_ACT: r.on = act & bl;
      `LMP_F_TX:      r.on = s.tx;
      `LMP_F_FDX:     r.on = s.fdx;
      `LMP_F_FDX_COL: r.on = s.fdx & ~(s.col & bl);
      `LMP_F_OFF:     r.on = 1'b0;
      `LMP_F_ON:      r.on = 1'b1;
      `LMP_F_A: begin
        r.on  = is5 ? 1'b0 : bl;
        r.hiz = is5;
      end
      `LMP_F_BLINK5:  r.on = is5 & bl;
      default:        r.on = 1'b0;
    endcase
    return r;
  endfunction

  // Polarity: bit 0 picks the on level, bit 1 floats the off state.
  function automatic lmp_pin_t pin_drive(
    input logic [1:0] pol,
    input lmp_lamp_t  l
  );
    lmp_pin_t p;
    p.o    = l.on ? pol[0] : ~pol[0];
    p.oe_n = l.hiz | (pol[1] & ~l.on);
    return p;
  endfunction

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  logic                    ap_valid;
  logic                    dp_wr_r;
  logic [`LMP_ADDR_W-1:0]  dp_idx_r;
  logic [`LMP_ADDR_W-1:0]  ap_idx;
  logic                    wr_func;
  logic                    wr_ctrl;
  logic                    srst_pulse;

  // Only whole-word accesses write; smaller sizes complete but are dropped.
  assign ap_valid  = hsel & htrans[1] & hready;
  assign ap_idx    = haddr[`LMP_ADDR_W+`LMP_BYTES_SH-1:`LMP_BYTES_SH];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_func   = dp_wr_r & (dp_idx_r == `LMP_IDX_FUNC);
  assign wr_ctrl   = dp_wr_r & (dp_idx_r == `LMP_IDX_CTRL);
  assign srst_pulse = wr_ctrl & hwdata[`LMP_CTRL_SRST];

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dp_wr_r  <= 1'b0;
      dp_idx_r <= '0;
    end else begin
      dp_wr_r  <= ap_valid & hwrite & (hsize == 3'h2);
      dp_idx_r <= ap_idx;
    end
  end

  // ****************************************************************
  // Function and polarity register
  // ****************************************************************
  logic [15:0] func_r;
  logic [15:0] func_nxt;
  logic        load_pend_r;
  logic [1:0]  strap_r;
  logic [3:0]  fn5_strap;
  logic [3:0]  fn4_strap;

  assign fn5_strap = (lamp_config_strap == `LMP_STRAP_01) ?
                     `LMP_FN5_S01 : `LMP_FN5_SDEF;
  assign fn4_strap = (lamp_config_strap == `LMP_STRAP_01) ?
                     `LMP_FN4_S01 : `LMP_FN4_SDEF;

  // Bits 15:12 are stored as written; software keeps them zero.
  always_comb begin
    func_nxt = func_r;
    if (load_pend_r) begin
      func_nxt = {`LMP_RSV_RST, `LMP_POL_RST, `LMP_POL_RST,
                  fn5_strap, fn4_strap};
    end else if (wr_func) begin
      func_nxt = hwdata[15:0];
    end
  end

  // The strap is sampled on the first edge after release, never by reset.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      func_r      <= `LMP_FUNC_RST;
      load_pend_r <= 1'b1;
      strap_r     <= '0;
    end else begin
      func_r      <= func_nxt;
      load_pend_r <= 1'b0;
      if (load_pend_r) begin
        strap_r <= lamp_config_strap;
      end
    end
  end

  // ****************************************************************
  // Blink generator
  // ****************************************************************
  // Soft reset restarts only the blink phase; the register survives.
  logic [31:0] blk_cnt_r;
  logic        blink_r;
  logic        blk_wrap;

  assign blk_wrap = (blk_cnt_r == 32'(BLINK_CYC - 1));

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      blk_cnt_r <= '0;
      blink_r   <= 1'b0;
    end else if (srst_pulse) begin
      blk_cnt_r <= '0;
      blink_r   <= 1'b0;
    end else begin
      blk_cnt_r <= blk_wrap ? '0 : blk_cnt_r + 32'h0000_0001;
      blink_r   <= blink_r ^ blk_wrap;
    end
  end

  // ****************************************************************
  // Lamp selection
  // ****************************************************************
  logic [3:0] fn4;
  logic [3:0] fn5;
  logic [1:0] pol4;
  logic [1:0] pol5;
  logic       dual;
  logic       act;
  lmp_lamp_t  l4_single;
  lmp_lamp_t  l5_single;
  lmp_lamp_t  l4_dual;
  lmp_lamp_t  l5_dual;
  lmp_lamp_t  l4;
  lmp_lamp_t  l5;

  assign fn4  = func_r[`LMP_FN4_HI:`LMP_FN4_LO];
  assign fn5  = func_r[`LMP_FN5_HI:`LMP_FN5_LO];
  assign pol4 = func_r[`LMP_POL4_HI:`LMP_POL4_LO];
  assign pol5 = func_r[`LMP_POL5_HI:`LMP_POL5_LO];
  assign dual = (fn4[`LMP_DUAL_HI:`LMP_DUAL_LO] == `LMP_DUAL_SEL);
  assign act  = ind.rx | ind.tx;

  assign l4_single = lamp_eval(fn4, 1'b0, ind, blink_r);
  assign l5_single = lamp_eval(fn5, 1'b1, ind, blink_r);

  // Bi-colour pairs: lamp 4 is one colour, lamp 5 the other.
  always_comb begin
    l4_dual = '0;
    l5_dual = '0;
    case (fn4)
      `LMP_F_DUAL1: begin
        l4_dual.on = ind.link;
        l5_dual.on = act;
      end
      `LMP_F_DUAL2: begin
        l4_dual.on = ind.link & ~act;
        l5_dual.on = act & blink_r;
      end
      `LMP_F_DUAL4: begin
        l4_dual.on = ind.link & ind.fdx;
        l5_dual.on = ind.link & ~ind.fdx;
      end
      default: begin
        l4_dual = '0;
        l5_dual = '0;
      end
    endcase
  end

  assign l4 = dual ? l4_dual : l4_single;
  assign l5 = dual ? l5_dual : l5_single;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lamp4_pin <= '{o: 1'b0, oe_n: 1'b1};
      lamp5_pin <= '{o: 1'b0, oe_n: 1'b1};
    end else begin
      lamp4_pin <= pin_drive(pol4, l4);
      lamp5_pin <= pin_drive(pol5, l5);
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Read data uses the next register value, so a read right after a
  // write returns the new contents without a wait state.
  logic [31:0] rd_nxt;
  logic [31:0] stat_word;

  assign stat_word = {26'h0, strap_r, 1'b0, dual, l5.on, l4.on};
  assign rd_nxt = (ap_idx == `LMP_IDX_FUNC) ? {16'h0, func_nxt} :
                  (ap_idx == `LMP_IDX_STAT) ? stat_word : 32'h0;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= '0;
    end else if (ap_valid & ~hwrite) begin
      hrdata <= rd_nxt;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Pin checks look one edge ahead, since the pins are registered.
  sequence s_soft_rst;
    srst_pulse & ~wr_func;
  endsequence

  sequence s_fields_kept;
    $stable(func_r) ##1 $stable(func_r);
  endsequence

  a_pol_drive5: assert property (@(posedge mclk)
    disable iff (sys_rst) !load_pend_r |=>
      lamp5_pin.o == ($past(l5.on) ~^ $past(pol5[0])))
    else $error("lamp 5 level wrong for polarity");

  a_pol_float5: assert property (@(posedge mclk)
    disable iff (sys_rst) (pol5[1] & ~l5.on) |=> lamp5_pin.oe_n)
    else $error("lamp 5 off state not floated");

  a_pol_float4: assert property (@(posedge mclk)
    disable iff (sys_rst) (pol4[1] & ~l4.on & ~l4.hiz) |=> lamp4_pin.oe_n)
    else $error("lamp 4 off state not floated");

  a_dual_ignore: assert property (@(posedge mclk)
    disable iff (sys_rst) dual |-> (l5.on == l5_dual.on) && !l5.hiz)
    else $error("lamp 5 code used in dual mode");

  a_dual_force5: assert property (@(posedge mclk)
    disable iff (sys_rst)
      (dual && fn5 == `LMP_F_ON && !ind.link && !act) |-> !l5.on)
    else $error("lamp 5 force code acts in dual mode");

  a_rx_code5: assert property (@(posedge mclk)
    disable iff (sys_rst) (!dual && fn5 == `LMP_F_RX) |-> l5.on == ind.rx)
    else $error("lamp 5 receive code wrong");

  a_fdx_col5: assert property (@(posedge mclk)
    disable iff (sys_rst)
      (!dual && fn5 == `LMP_F_FDX_COL && !ind.fdx) |-> !l5.on)
    else $error("lamp 5 lit at half duplex");

  a_force_hiz5: assert property (@(posedge mclk)
    disable iff (sys_rst) (!dual && fn5 == `LMP_F_A) |=> lamp5_pin.oe_n)
    else $error("lamp 5 not high impedance");

  a_strap_load: assert property (@(posedge mclk)
    disable iff (sys_rst) load_pend_r |=>
      fn5 == $past(fn5_strap) && fn4 == $past(fn4_strap))
    else $error("strap defaults not loaded");

  a_blink_code4: assert property (@(posedge mclk)
    disable iff (sys_rst) (fn4 == `LMP_F_A) |-> l4.on == blink_r && !l4.hiz)
    else $error("lamp 4 code 1010 not blinking");

  a_fdx_code4: assert property (@(posedge mclk)
    disable iff (sys_rst) (fn4 == `LMP_F_FDX) |-> l4.on == ind.fdx)
    else $error("lamp 4 duplex code wrong");

  a_dual4_mode: assert property (@(posedge mclk)
    disable iff (sys_rst) (fn4 == `LMP_F_DUAL4) |->
      (l4.on ^ l5.on) == ind.link)
    else $error("dual mode 4 colours wrong");

  a_dual2_link: assert property (@(posedge mclk)
    disable iff (sys_rst) (fn4 == `LMP_F_DUAL2 && act) |-> !l4.on && !l5.hiz)
    else $error("dual mode 2 link colour lit during activity");

  a_soft_keep: assert property (@(posedge mclk)
    disable iff (sys_rst)
      (s_soft_rst ##1 (!wr_func && !load_pend_r)) |-> s_fields_kept)
    else $error("soft reset changed the fields");

  a_pol_cleared: assert property (@(posedge mclk)
    disable iff (sys_rst) load_pend_r |=>
      pol4 == `LMP_POL_RST && pol5 == `LMP_POL_RST)
    else $error("polarity not cleared by reset");

endmodule // lmp_lamp54
`default_nettype wire

// File: lmp_lamp_model.sv
// Behavioural model of one indicator lamp hanging on a lamp pin.
// Assumes the pin is the design's registered {o, oe_n} pair on mclk.
`timescale 1ns/1ps
`default_nettype none
module lmp_lamp_model (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire lmp_pkg::lmp_pin_t pin,
  output logic                   lvl,
  output logic                   floated
);
  import lmp_pkg::*;
  logic last_r;
  // ****************************************************************
  // Pad level
  // ****************************************************************
  // A released pad shows the inverse of its last driven level, so a
  // pin that floats by mistake cannot pass for the level it last drove.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      last_r <= 1'b0;
    end else if (!pin.oe_n) begin
      last_r <= pin.o;
    end
  end
  assign floated = pin.oe_n;
  assign lvl     = pin.oe_n ? ~last_r : pin.o;
endmodule // lmp_lamp_model
`default_nettype wire

// File: lmp_pkg.sv
// Types shared by the lamp 4/5 block and whoever instantiates it.
// Assumes the constants header is on the include path.
`default_nettype none
package lmp_pkg;
  `include "lmp_regs.svh"

  // Link and traffic conditions that the lamps can show.
  typedef struct packed {
    logic link;
    logic rx;
    logic tx;
    logic fdx;
    logic col;
  } lmp_ind_t;

  // One lamp pin: level and active-low output enable.
  typedef struct packed {
    logic o;
    logic oe_n;
  } lmp_pin_t;

  // Logical lamp state before polarity is applied.
  typedef struct packed {
    logic on;
    logic hiz;
  } lmp_lamp_t;
endpackage
`default_nettype wire

// File: lmp_regs.svh
// Constants for the lamp 4/5 function and polarity block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef LMP_REGS_SVH
`define LMP_REGS_SVH

// ****************************************************************
// Register indices and byte addresses
// ****************************************************************
`define LMP_IDX_FUNC   8'h13
`define LMP_IDX_CTRL   8'h14
`define LMP_IDX_STAT   8'h15
`define LMP_ADDR_W     8
`define LMP_BYTES_SH   2

// ****************************************************************
// Field positions
// ****************************************************************
`define LMP_RSV_HI     15
`define LMP_RSV_LO     12
`define LMP_POL5_HI    11
`define LMP_POL5_LO    10
`define LMP_POL4_HI    9
`define LMP_POL4_LO    8
`define LMP_FN5_HI     7
`define LMP_FN5_LO     4
`define LMP_FN4_HI     3
`define LMP_FN4_LO     0
`define LMP_DUAL_HI    3
`define LMP_DUAL_LO    2
`define LMP_CTRL_SRST  0
`define LMP_ST_ON4     0
`define LMP_ST_ON5     1
`define LMP_ST_DUAL    2
`define LMP_ST_STR_LO  4
`define LMP_ST_STR_HI  5

// ****************************************************************
// Function codes
// ****************************************************************
`define LMP_F_RX       4'h0
`define LMP_F_LNK_ACT  4'h1
`define LMP_F_LNK_RX   4'h2
`define LMP_F_ACT      4'h3
`define LMP_F_BLK_ACT  4'h4
`define LMP_F_TX       4'h5
`define LMP_F_FDX      4'h6
`define LMP_F_FDX_COL  4'h7
`define LMP_F_OFF      4'h8
`define LMP_F_ON       4'h9
`define LMP_F_A        4'hA
`define LMP_F_BLINK5   4'hB
`define LMP_F_DUAL1    4'hC
`define LMP_F_DUAL2    4'hE
`define LMP_F_DUAL4    4'hF
`define LMP_DUAL_SEL   2'h3

// ****************************************************************
// Reset values and strap encodings
// ****************************************************************
`define LMP_POL_RST    2'h0
`define LMP_RSV_RST    4'h0
`define LMP_STRAP_01   2'h1
`define LMP_FN5_S01    4'h4
`define LMP_FN5_SDEF   4'h7
`define LMP_FN4_S01    4'h6
`define LMP_FN4_SDEF   4'h3
`define LMP_FUNC_RST   16'h0073

// ****************************************************************
// Timing
// ****************************************************************
`define LMP_CLK_NS     5
`define LMP_BLINK_NS   84000000

`endif

// File: testbench.sv
// Self-checking bench for the lamp 4/5 function and polarity block.
// Assumes lmp_pkg, the design and the lamp model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "lmp_regs.svh"
module testbench;
  import lmp_pkg::*;
  localparam logic [31:0] A_FUNC = 32'(`LMP_IDX_FUNC) << `LMP_BYTES_SH;
  localparam logic [31:0] A_CTRL = 32'(`LMP_IDX_CTRL) << `LMP_BYTES_SH;
  localparam logic [31:0] A_STAT = 32'(`LMP_IDX_STAT) << `LMP_BYTES_SH;
  localparam logic [31:0] A_NONE = 32'h0000_007C;
  // Indications per code, code 7 first; code 4 is expected dark.
  localparam logic [39:0] IND_TAB = {5'h02, 5'h02, 5'h04, 5'h10,
                                     5'h04, 5'h10, 5'h10, 5'h08};
  localparam logic [7:0]  EXP_ON  = 8'hEF;
  logic        mclk, sys_rst, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans, strap;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  lmp_ind_t    ind;
  lmp_pin_t    lamp4_pin, lamp5_pin;
  logic        lvl4, lvl5, flt4, flt5;
  int          num_errors, comparisons, n4, n5;

  lmp_lamp54 #(.BLINK_CYC(4)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .lamp_config_strap(strap), .ind(ind),
    .lamp4_pin(lamp4_pin), .lamp5_pin(lamp5_pin));
  lmp_lamp_model m4 (.mclk(mclk), .sys_rst(sys_rst), .pin(lamp4_pin),
                     .lvl(lvl4), .floated(flt4));
  lmp_lamp_model m5 (.mclk(mclk), .sys_rst(sys_rst), .pin(lamp5_pin),
                     .lvl(lvl5), .floated(flt5));

  always #2.5 mclk = ~mclk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "response");
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp, "read");
  endtask

  // Pins as {o, oe_n}; the level of a floated pin is not compared.
  task automatic pchk(input lmp_pin_t p, input logic on,
                      input logic [1:0] pol, input string m);
    logic [1:0] e;
    e = on ? {pol[0], 1'b0} : (pol[1] ? {p.o, 1'b1} : {~pol[0], 1'b0});
    chk({30'h0, p}, {30'h0, e}, m);
  endtask

  task automatic settle();
    repeat (2) @(posedge mclk);
  endtask

  task automatic hw_reset(input logic [1:0] s);
    @(posedge mclk);
    sys_rst <= 1'b1;
    strap   <= s;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic toggles();
    logic p4, p5;
    n4 = 0;
    n5 = 0;
    p4 = lvl4;
    p5 = lvl5;
    repeat (30) begin
      @(posedge mclk);
      if (lvl4 !== p4) n4++;
      if (lvl5 !== p5) n5++;
      p4 = lvl4;
      p5 = lvl5;
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    strap = 2'b00;
    ind = '0;
    num_errors = 0;
    comparisons = 0;
    for (int s = 0; s < 4; s++) begin
      hw_reset(2'(s));
      rchk(A_FUNC, {24'h0, (s == 1) ? 8'h46 : 8'h73});
    end
    $display("test strap reset done");
    for (int p = 0; p < 4; p++) begin
      for (int on = 0; on < 2; on++) begin
        ahb(1'b1, A_FUNC, {20'h0, 2'(p), 2'(p), on[0] ? 8'h99 : 8'h88});
        settle();
        pchk(lamp5_pin, on[0], 2'(p), "lamp5 drive");
        pchk(lamp4_pin, on[0], 2'(p), "lamp4 drive");
      end
    end
    $display("test polarity done");
    for (int k = 0; k < 8; k++) begin
      ahb(1'b1, A_FUNC, {20'h0, 4'h5, 4'(k), 4'(k)});
      ind <= lmp_ind_t'(IND_TAB[5*k +: 5]);
      settle();
      pchk(lamp5_pin, EXP_ON[k], 2'b01, "lamp5 function");
      pchk(lamp4_pin, EXP_ON[k], 2'b01, "lamp4 function");
      ind <= '0;
      settle();
      pchk(lamp5_pin, 1'b0, 2'b01, "lamp5 idle");
      pchk(lamp4_pin, 1'b0, 2'b01, "lamp4 idle");
    end
    $display("test function codes done");
    ahb(1'b1, A_FUNC, 32'h059C);
    settle();
    pchk(lamp5_pin, 1'b0, 2'b01, "dual1 ignores force");
    pchk(lamp4_pin, 1'b0, 2'b01, "dual1 no link");
    ind <= lmp_ind_t'(5'h04);
    settle();
    pchk(lamp5_pin, 1'b1, 2'b01, "dual1 activity");
    ahb(1'b1, A_FUNC, 32'h059F);
    ind <= lmp_ind_t'(5'h12);
    settle();
    pchk(lamp4_pin, 1'b1, 2'b01, "dual4 full duplex");
    pchk(lamp5_pin, 1'b0, 2'b01, "dual4 full duplex");
    ind <= lmp_ind_t'(5'h10);
    settle();
    pchk(lamp4_pin, 1'b0, 2'b01, "dual4 half duplex");
    pchk(lamp5_pin, 1'b1, 2'b01, "dual4 half duplex");
    ahb(1'b1, A_FUNC, 32'h059E);
    ind <= lmp_ind_t'(5'h14);
    settle();
    pchk(lamp4_pin, 1'b0, 2'b01, "dual2 activity");
    ind <= lmp_ind_t'(5'h10);
    settle();
    pchk(lamp4_pin, 1'b1, 2'b01, "dual2 link idle");
    pchk(lamp5_pin, 1'b0, 2'b01, "dual2 link idle");
    ind <= '0;
    $display("test dual modes done");
    ahb(1'b1, A_FUNC, 32'h05BA);
    settle();
    toggles();
    chk({31'h0, n4 >= 6 && n4 <= 8}, 32'h1, "lamp4 blink");
    chk({31'h0, n5 >= 6 && n5 <= 8}, 32'h1, "lamp5 blink");
    ahb(1'b1, A_FUNC, 32'h0544);
    ind <= lmp_ind_t'(5'h04);
    settle();
    toggles();
    chk({31'h0, n4 >= 6 && n4 <= 8}, 32'h1, "lamp4 activity blink");
    chk({31'h0, n5 >= 6 && n5 <= 8}, 32'h1, "lamp5 activity blink");
    ind <= '0;
    ahb(1'b1, A_FUNC, 32'h05A9);
    settle();
    chk({31'h0, flt5}, 32'h1, "lamp5 high impedance");
    pchk(lamp4_pin, 1'b1, 2'b01, "lamp4 force on");
    $display("test blink and float done");
    ahb(1'b1, A_FUNC, 32'h0563);
    ahb(1'b1, A_CTRL, 32'h1);
    rchk(A_FUNC, 32'h0000_0563);
    rchk(A_NONE, 32'h0);
    rchk(A_STAT, 32'h0000_0030);
    $display("test soft reset done");
    final_report();
  end

  // Whole run is a few hundred cycles; this only catches a hang.
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end
endmodule // testbench
`default_nettype wire
